// file: verilog/pdlr_pkg.sv
// Purpose: Shared constants and types for the mode-dependent lane router
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   Offsets are byte addresses
package pdlr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PDLR_OFF_CTRL   = 8'h00;
  localparam logic [7:0] PDLR_OFF_TXEQ   = 8'h04;
  localparam logic [7:0] PDLR_OFF_MON    = 8'h08;
  localparam logic [7:0] PDLR_OFF_STATUS = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int PDLR_CTRL_MODE_LSB   = 0;   // [1:0] operating mode
  localparam int PDLR_CTRL_HIF        = 2;   // 1: two-lane host interface
  localparam int PDLR_CTRL_LANE3      = 3;   // 1: 1 GbE on lane 3
  localparam int PDLR_CTRL_TS_EN      = 4;
  localparam int PDLR_CTRL_SEC_EN     = 5;
  localparam int PDLR_CTRL_MAC_EN     = 6;
  localparam int PDLR_CTRL_LOOP       = 7;
  localparam int PDLR_CTRL_SQW        = 8;
  localparam int PDLR_CTRL_DP_RST     = 9;
  localparam int PDLR_TAP_W           = 4;
  localparam int PDLR_TXEQ_PRE_LSB    = 0;
  localparam int PDLR_TXEQ_MAIN_LSB   = 8;
  localparam int PDLR_TXEQ_POST_LSB   = 16;
  localparam int PDLR_MON_EN          = 0;
  localparam int PDLR_MON_UNITY       = 1;
  localparam int PDLR_MON_ADAPT_DIS   = 2;
  localparam logic [31:0] PDLR_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PDLR_TXEQ_RST = 32'h0000_0f00;
  localparam logic [31:0] PDLR_MON_RST  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Timing and pattern constants
  // ----------------------------------------------------------------
  localparam int PDLR_SQW_RUN     = 8;  // Least run of ones in square wave
  localparam int PDLR_LSYNC_DIV   = 4;  // Words per lane-sync period
  localparam int PDLR_WORD_W      = 32;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PDLR_MODE_LAN = 2'h0,
    PDLR_MODE_WAN = 2'h1,
    PDLR_MODE_1G  = 2'h2
  } pdlr_mode_e;

  typedef enum logic [2:0] {
    PDLR_PATH_PCS10 = 3'h1,
    PDLR_PATH_WIS   = 3'h2,
    PDLR_PATH_PCS1  = 3'h4
  } pdlr_path_e;

  typedef struct packed {
    logic [31:0] data;
    logic        valid;
  } pdlr_word_s;

  typedef struct packed {
    logic [3:0] lane_en;
    logic       enc_8b10b;
    logic       two_lane;
  } pdlr_host_s;

endpackage

// file: verilog/pdlr_router.sv
// Purpose: Mode-dependent data-path steering for a 10G/1G Ethernet PHY channel
// Assumes: pclk 50 MHz; serial-rate stages are outside; words arrive on pclk
// Notes:   Registers over APB; one clock, slower rates by enable pulses
`timescale 1ns/1ps
module pdlr_router
  import pdlr_pkg::*;
#(
  parameter int TAP_W = PDLR_TAP_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire pdlr_word_s        line_rx_word,
  input  wire logic              rx_pll_locked,
  output pdlr_word_s             line_tx_word,
  output pdlr_path_e             ingress_path,
  output pdlr_path_e             egress_path,
  output logic                   stages_bypassed,
  output logic                   line_rate_wan,
  input  wire pdlr_word_s [3:0]  host_rx_lane,
  output pdlr_word_s [3:0]       host_tx_lane,
  output pdlr_host_s             host_cfg,
  output logic                   lane_sync,
  output logic [3*(1<<TAP_W)-1:0] txeq_therm,
  output logic [2:0]             tap_chain,
  output logic                   mon_active,
  output logic                   dfe_zero
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] txeq_r;
  logic [31:0] mon_r;
  logic        wr_en;
  logic        addr_ok;
  pdlr_mode_e  mode;
  logic [31:0] status_word;
  pdlr_word_s  line_tx_nxt;
  pdlr_word_s [3:0] host_tx_nxt;
  logic [1:0]  lsync_cnt_r;
  logic [2:0]  sqw_cnt_r;
  logic        sqw_lvl_r;
  logic        rx_lock_s1_r;
  logic        rx_lock_s2_r;

  assign wr_en   = psel && penable && pwrite;
  assign addr_ok = (paddr == PDLR_OFF_CTRL) || (paddr == PDLR_OFF_TXEQ) ||
                   (paddr == PDLR_OFF_MON) || (paddr == PDLR_OFF_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  // Lock is read through the synchroniser, never from the raw pin
  assign status_word = {26'h0, rx_lock_s2_r, mon_active, dfe_zero,
                        line_rate_wan, ingress_path[1:0]};

  // Control word; the data-path reset bit lives one cycle after its write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= PDLR_CTRL_RST;
    end else if (wr_en && (paddr == PDLR_OFF_CTRL)) begin
      ctrl_r <= pwdata;
    end else begin
      ctrl_r[PDLR_CTRL_DP_RST] <= 1'b0;
    end
  end

  // Equalizer codes, one byte lane per tap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txeq_r <= PDLR_TXEQ_RST;
    end else if (wr_en && (paddr == PDLR_OFF_TXEQ)) begin
      txeq_r <= pwdata;
    end
  end

  // Monitor controls; software clears adaptation before asking for unity gain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_r <= PDLR_MON_RST;
    end else if (wr_en && (paddr == PDLR_OFF_MON)) begin
      mon_r <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        PDLR_OFF_CTRL:   prdata <= ctrl_r;
        PDLR_OFF_TXEQ:   prdata <= txeq_r;
        PDLR_OFF_MON:    prdata <= mon_r;
        PDLR_OFF_STATUS: prdata <= status_word;
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // single mode field; one WAN flag serves both directions
  always_comb begin
    case (ctrl_r[PDLR_CTRL_MODE_LSB +: 2])
      2'h1:    mode = PDLR_MODE_WAN;
      2'h2:    mode = PDLR_MODE_1G;
      // Unused code 3 falls back to LAN rather than leaving the path undefined
      default: mode = PDLR_MODE_LAN;
    endcase
  end

  always_comb begin
    case (mode)
      PDLR_MODE_WAN: ingress_path = PDLR_PATH_WIS;
      // 1G ingress via line-side 1G PCS
      PDLR_MODE_1G:  ingress_path = PDLR_PATH_PCS1;
      // LAN ingress straight to 10G PCS
      default:       ingress_path = PDLR_PATH_PCS10;
    endcase
  end

  // LAN egress ends in 10G PCS, WAN egress in WIS; 1G egress ends in line 1G PCS
  assign egress_path = ingress_path;
  // line rate choice follows WAN framing
  assign line_rate_wan = (mode == PDLR_MODE_WAN);
  // optional stages, bypassed when all disabled
  assign stages_bypassed = !(ctrl_r[PDLR_CTRL_TS_EN] | ctrl_r[PDLR_CTRL_SEC_EN] |
                             ctrl_r[PDLR_CTRL_MAC_EN]);

  // ----------------------------------------------------------------
  // Host lane steering
  // ----------------------------------------------------------------
  always_comb begin
    host_cfg.enc_8b10b = 1'b1;
    host_cfg.two_lane  = 1'b0;
    if (mode == PDLR_MODE_1G) begin
      // one lane, 0 or 3, same for both directions
      host_cfg.lane_en = ctrl_r[PDLR_CTRL_LANE3] ? 4'h8 : 4'h1;
    end else if (ctrl_r[PDLR_CTRL_HIF]) begin
      // two-lane mode uses lanes 0 and 2
      host_cfg.lane_en  = 4'h5;
      host_cfg.two_lane = 1'b1;
    end else begin
      host_cfg.lane_en = 4'hf;
    end
  end

  // ----------------------------------------------------------------
  // Data-path words
  // ----------------------------------------------------------------
  // Test pattern outranks loopback, loopback outranks host data
  always_comb begin
    line_tx_nxt = host_rx_lane[0];
    if (ctrl_r[PDLR_CTRL_SQW]) begin
      line_tx_nxt = '{data: {PDLR_WORD_W{sqw_lvl_r}}, valid: 1'b1};
    end else if (ctrl_r[PDLR_CTRL_LOOP]) begin
      // line receive looped to line transmit
      line_tx_nxt = line_rx_word;
    end else if (mode == PDLR_MODE_1G) begin
      // egress takes the selected lane only
      line_tx_nxt = ctrl_r[PDLR_CTRL_LANE3] ? host_rx_lane[3] : host_rx_lane[0];
    end else begin
      // 10G egress takes lane 0; decode and deskew sit upstream
      line_tx_nxt = host_rx_lane[0];
    end
  end

  // 32-bit words with valid strobe onto enabled lanes
  for (genvar l = 0; l < 4; l++) begin : g_lane
    assign host_tx_nxt[l] = host_cfg.lane_en[l] ? line_rx_word : '0;
  end

  // data-path reset flushes words after mode changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_tx_lane <= '0;
      line_tx_word <= '0;
    end else if (ctrl_r[PDLR_CTRL_DP_RST]) begin
      // Old-mode words would reach the wrong lane, so they are dropped
      host_tx_lane <= '0;
      line_tx_word <= '0;
    end else begin
      host_tx_lane <= host_tx_nxt;
      line_tx_word <= line_tx_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Square wave and lane sync
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sqw_cnt_r <= 3'h0;
      sqw_lvl_r <= 1'b1;
    end else begin
      sqw_cnt_r <= sqw_cnt_r + 3'h1;
      if (sqw_cnt_r == 3'(PDLR_SQW_RUN - 1)) begin
        sqw_lvl_r <= !sqw_lvl_r;
      end
    end
  end

  // Two-stage sync: lock comes from the analog PLL domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_lock_s1_r <= 1'b0;
      rx_lock_s2_r <= 1'b0;
    end else begin
      rx_lock_s1_r <= rx_pll_locked;
      rx_lock_s2_r <= rx_lock_s1_r;
    end
  end

  // lane sync pulse only while locked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsync_cnt_r <= 2'h0;
      lane_sync   <= 1'b0;
    end else begin
      lsync_cnt_r <= rx_lock_s2_r ? lsync_cnt_r + 2'h1 : 2'h0;
      lane_sync   <= rx_lock_s2_r && (lsync_cnt_r == 2'(PDLR_LSYNC_DIV - 1));
    end
  end

  // ----------------------------------------------------------------
  // Transmit equalizer
  // ----------------------------------------------------------------
  genvar t;
  generate
    for (t = 0; t < 3; t++) begin : g_tap
      logic [TAP_W-1:0] code;
      assign code = txeq_r[8*t +: TAP_W];
      for (genvar b = 0; b < (1<<TAP_W); b++) begin : g_bit
        assign txeq_therm[t*(1<<TAP_W)+b] = (b < code);
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_chain <= 3'h0;
    end else begin
      tap_chain <= {tap_chain[1:0], line_tx_word.data[0]};
    end
  end

  // ----------------------------------------------------------------
  // Signal monitor gating
  // ----------------------------------------------------------------
  // monitor only in 10G modes
  assign mon_active = mon_r[PDLR_MON_EN] && (mode != PDLR_MODE_1G);
  // unity gain with adaptation disabled, while the monitor is active, forces DFE taps to zero
  assign dfe_zero = mon_active && mon_r[PDLR_MON_UNITY] && mon_r[PDLR_MON_ADAPT_DIS];

endmodule // pdlr_router

// file: testbench/pdlr_sva.sv
// Purpose: Port assertions for pdlr_router
// Assumes: One pclk domain
// Notes:   Bound to every instance
`timescale 1ns/1ps
module pdlr_sva
  import pdlr_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic [7:0]       paddr,
  input wire logic             pslverr,
  input wire pdlr_word_s       line_tx_word,
  input wire pdlr_path_e       ingress_path,
  input wire pdlr_path_e       egress_path,
  input wire logic             line_rate_wan,
  input wire pdlr_word_s [3:0] host_tx_lane,
  input wire pdlr_host_s       host_cfg,
  input wire logic             lane_sync,
  input wire logic [2:0]       tap_chain,
  input wire logic             mon_active
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_gap; !lane_sync [*3]; endsequence
  property p_path_pair; ingress_path == egress_path; endproperty
  a_path_pair: assert property (p_path_pair) else $error("paths differ");
  property p_wan; line_rate_wan == (ingress_path == PDLR_PATH_WIS); endproperty
  a_wan: assert property (p_wan) else $error("rate and path differ");
  property p_rxaui; host_cfg.two_lane && ingress_path != PDLR_PATH_PCS1
    |-> host_cfg.lane_en == 4'h5; endproperty
  a_rxaui: assert property (p_rxaui) else $error("two-lane mask wrong");
  property p_gbe; ingress_path == PDLR_PATH_PCS1 |-> host_cfg.lane_en inside {4'h1, 4'h8};
  endproperty
  a_gbe: assert property (p_gbe) else $error("1G lane mask wrong");
  property p_off; !host_cfg.lane_en[1] && !$past(host_cfg.lane_en[1]) |-> host_tx_lane[1] == '0;
  endproperty
  a_off: assert property (p_off) else $error("disabled lane carries data");
  property p_mon; ingress_path == PDLR_PATH_PCS1 |-> !mon_active; endproperty
  a_mon: assert property (p_mon) else $error("monitor active in 1G");
  property p_sync; lane_sync |=> s_gap ##1 lane_sync; endproperty
  a_sync: assert property (p_sync) else $error("lane sync spacing");
  property p_tap; 1'b1 |=> tap_chain == {$past(tap_chain[1:0]), $past(line_tx_word.data[0])};
  endproperty
  a_tap: assert property (p_tap) else $error("tap chain shift");
  property p_unmap; psel && penable && paddr > 8'h0c |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("no error on unmapped");
endmodule // pdlr_sva

bind pdlr_router pdlr_sva u_sva (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
  .line_tx_word, .ingress_path, .egress_path, .line_rate_wan, .host_tx_lane, .host_cfg,
  .lane_sync, .tap_chain, .mon_active);

// file: testbench/pdlr_host_model.sv
// Purpose: Host MAC model on the lane side
// Assumes: Words move on pclk
// Notes:   Idle lanes show inverted data, never a held value
`timescale 1ns/1ps
module pdlr_host_model
  import pdlr_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire pdlr_host_s host_cfg,
  output pdlr_word_s [3:0] host_rx_lane
);
  // ----------------------------------------------------------------
  // Lane drive
  // ----------------------------------------------------------------
  initial host_rx_lane = '0;
  always @(posedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      if (presetn && host_cfg.lane_en[i])
        host_rx_lane[i] <= '{data: $urandom, valid: 1'b1};
      else
        host_rx_lane[i] <= ~host_rx_lane[i];
    end
  end
endmodule // pdlr_host_model

// file: testbench/pdlr_router_bench.sv
// Purpose: Self-checking bench for pdlr_router
// Assumes: 50 MHz pclk, APB master
// Notes:   Expectations come from a small model
`timescale 1ns/1ps
module pdlr_router_bench;
  import pdlr_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic             rx_pll_locked, stages_bypassed, line_rate_wan, lane_sync;
  logic             mon_active, dfe_zero;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd;
  pdlr_word_s       line_rx_word, line_tx_word, w, e;
  logic [3:0]       en;
  pdlr_word_s [3:0] host_rx_lane, host_tx_lane;
  pdlr_path_e       ingress_path, egress_path;
  pdlr_host_s       host_cfg;
  logic [47:0]      txeq_therm, th;
  logic [2:0]       tap_chain;
  logic [3:0]       code [3];
  int               n_fail, n_compared, m, c, run, best, ns, sel;
  pdlr_word_s       q[$];

  pdlr_router dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .line_rx_word, .rx_pll_locked, .line_tx_word, .ingress_path, .egress_path,
    .stages_bypassed, .line_rate_wan, .host_rx_lane, .host_tx_lane, .host_cfg, .lane_sync,
    .txeq_therm, .tap_chain, .mon_active, .dfe_zero);
  pdlr_host_model u_host (.pclk, .presetn, .host_cfg, .host_rx_lane);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      conclude();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    line_rx_word  = '0;
    rx_pll_locked = 1'b1;
    presetn       = 1'b0;
    n_fail        = 0;
    n_compared    = 0;
    void'($urandom(65));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, PDLR_OFF_TXEQ, 0);
    chk(rd, PDLR_TXEQ_RST, "txeq reset");
    chk(txeq_therm, 48'h0000_7fff_0000, "therm reset");
    apb(0, 8'h10, 0);
    chk({err, rd}, 48'h1_0000_0000, "unmapped");
    apb(1, PDLR_OFF_MON, 32'h1);
    for (int i = 0; i < 12; i++) begin
      m = i % 3;
      c = $urandom & 32'h70;
      apb(1, PDLR_OFF_CTRL, c | ((i / 6) << 3) | (((i / 3) % 2) << 2) | m);
      @(posedge pclk);
      chk(ingress_path, 1 << m, "ingress");
      chk(egress_path, 1 << m, "egress");
      chk(line_rate_wan, m == 1, "rate");
      chk(stages_bypassed, c == 0, "stages");
      chk(host_cfg.lane_en, m == 2 ? (i / 6 ? 8 : 1) : ((i / 3) % 2 ? 5 : 15), "lanes");
      chk(mon_active, m != 2, "monitor");
    end
    repeat (4) begin
      th = '0;
      for (int t = 0; t < 3; t++) begin
        code[t] = 4'($urandom);
        th[16*t +: 16] = (16'h1 << code[t]) - 16'h1;
      end
      apb(1, PDLR_OFF_TXEQ, {12'h0, code[2], 4'h0, code[1], 4'h0, code[0]});
      @(posedge pclk);
      chk(txeq_therm, th, "therm");
    end
    apb(1, PDLR_OFF_CTRL, 32'h280);
    for (int i = 0; i < 12; i++) begin
      @(posedge pclk);
      if (q.size() == 2)
        chk(line_tx_word, q.pop_front(), "loopback");
      w = '{data: $urandom, valid: 1'b1};
      q.push_back(w);
      line_rx_word <= w;
    end
    // Host lanes both ways: two-lane LAN, then 1 GbE on lane 3
    for (int s = 0; s < 2; s++) begin
      sel = s ? 3 : 0;
      en  = s ? 4'h8 : 4'h5;
      q.delete();
      apb(1, PDLR_OFF_CTRL, s ? 32'h20a : 32'h204);
      for (int i = 0; i < 12; i++) begin
        @(posedge pclk);
        if (i > 1)
          chk(line_tx_word, w, "egress lane");
        if (q.size() == 2) begin
          e = q.pop_front();
          for (int j = 0; j < 4; j++)
            chk(host_tx_lane[j], en[j] ? e : '0, "ingress lane");
        end
        w = host_rx_lane[sel];
        e = '{data: $urandom, valid: 1'b1};
        q.push_back(e);
        line_rx_word <= e;
      end
      // adaptation off first, unity gain after
      apb(1, PDLR_OFF_MON, 32'h5);
      @(posedge pclk);
      chk(dfe_zero, 0, "dfe adaptive");
      apb(1, PDLR_OFF_MON, 32'h7);
      @(posedge pclk);
      chk(dfe_zero, s == 0, "dfe zero");
      apb(0, PDLR_OFF_STATUS, 0);
      chk(rd, s ? 32'h20 : 32'h39, "status");
    end
    // Square wave wins over loopback
    apb(1, PDLR_OFF_CTRL, 32'h380);
    run  = 0;
    best = 0;
    ns   = 0;
    repeat (40) begin
      @(posedge pclk);
      run  = line_tx_word.data[0] ? run + 1 : 0;
      best = run > best ? run : best;
      ns   = ns + lane_sync;
    end
    chk(best >= PDLR_SQW_RUN, 1, "square run");
    chk(ns, 40 / PDLR_LSYNC_DIV, "sync count");
    conclude();
  end
endmodule // pdlr_router_bench
